// file: pkg/cpt_pkg.sv
// Operation
// RULE1: Output pin goes high on proximity, low otherwise.
// RULE2: Comparator checks each result against fixed or adaptive threshold.
// RULE3: Adaptive threshold flags fast changes and ignores slow drift.
// RULE4: Fixed mode uses constant programmed threshold; any crossing asserts output.
// RULE5: Polarity selects positive or negative capacitance change in both modes.
// RULE6: Adaptive mode also offers in-window and out-window comparison.
// RULE7: Reference is running average settling exponentially per conversion.
// RULE8: Average time constant is power of two from 2 to 65536.
// RULE9: Offset DAC code is 6 bits, monotonic, higher code more offset.
// RULE10: Converter spans 4 pF; offset DAC cancels up to 10 pF.
// RULE11: Third-order filter turns modulator bitstream into result words.
// RULE12: Each result feeds comparator, average and a readable register.
// RULE13: Sensitivity programmable 0 to 255 LSBs of 12-bit result.
// RULE14: Adaptive threshold sits sensitivity above, below, or both around average.
// RULE15: Average and decision update once per conversion; pin changes only then.
package cpt_pkg;
    localparam int DATA_W = 12;
    localparam int CIC_W  = 13;
    localparam int FRAC_W = 16;
    localparam int ACC_W  = 30;
    localparam int DAC_W  = 6;
    localparam int SENS_W = 8;
    localparam int SEL_W  = 4;

    // Modulator sample rate and decimation
    localparam logic [7:0] SAMPLE_DIV = 8'h04;
    localparam logic [4:0] DECIM      = 5'h10;
    localparam logic [1:0] WARMUP     = 2'h3;
    localparam logic [CIC_W-1:0] CIC_FULL = 13'h1000;

    // Register byte offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_DATA   = 8'h04;
    localparam logic [7:0] ADDR_AVG    = 8'h08;
    localparam logic [7:0] ADDR_CFG    = 8'h0C;
    localparam logic [7:0] ADDR_SENS   = 8'h10;
    localparam logic [7:0] ADDR_FIXTHR = 8'h14;

    // Field positions in the configuration and status words
    localparam int CFG_MODE_LSB  = 0;
    localparam int CFG_FIXED_BIT = 2;
    localparam int CFG_SEL_LSB   = 4;
    localparam int CFG_DAC_LSB   = 8;
    localparam int ST_OUT_BIT    = 0;
    localparam int ST_RDY_BIT    = 1;
    localparam int ST_AVG_BIT    = 2;

    localparam logic [31:0] CFG_MASK    = 32'h0000_3FF7;
    localparam logic [31:0] SENS_MASK   = 32'h0000_00FF;
    localparam logic [31:0] FIXTHR_MASK = 32'h0000_0FFF;
    localparam logic [31:0] CFG_RST     = 32'h0000_0071;
    localparam logic [31:0] SENS_RST    = 32'h0000_0020;
    localparam logic [31:0] FIXTHR_RST  = 32'h0000_0800;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_NEG,
        MODE_POS,
        MODE_IN_WIN,
        MODE_OUT_WIN
    } cpt_mode_t;
endpackage

// file: pkg/cpt_conv_if.sv
`timescale 1ns/1ps
interface cpt_conv_if;
    import cpt_pkg::*;
    logic              samp_en;
    logic              mod_bit;
    logic [DATA_W-1:0] result;
    logic              result_valid;
    modport filt (input samp_en, input mod_bit, output result, output result_valid);
    modport host (output samp_en, output mod_bit, input result, input result_valid);
endinterface

// file: verilog/cpt_sinc3.sv
`timescale 1ns/1ps
module cpt_sinc3 (
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    cpt_conv_if.filt  conv
);
    import cpt_pkg::*;

    logic [CIC_W-1:0] integ1;
    logic [CIC_W-1:0] integ2;
    logic [CIC_W-1:0] integ3;
    logic [CIC_W-1:0] dly1;
    logic [CIC_W-1:0] dly2;
    logic [CIC_W-1:0] dly3;
    logic [CIC_W-1:0] comb1;
    logic [CIC_W-1:0] comb2;
    logic [CIC_W-1:0] comb3;
    logic [4:0]       dec_cnt;
    logic [1:0]       warm;
    logic             dump;

    // RULE11 third-order integrators
    // Modular wrap is harmless: output width covers full decimated range
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            integ1 <= '0;
            integ2 <= '0;
            integ3 <= '0;
        end else if (conv.samp_en) begin
            integ1 <= integ1 + {{(CIC_W-1){1'b0}}, conv.mod_bit};
            integ2 <= integ2 + integ1;
            integ3 <= integ3 + integ2;
        end
    end

    assign dump  = conv.samp_en && (dec_cnt == DECIM - 5'h01);
    assign comb1 = integ3 - dly1;
    assign comb2 = comb1 - dly2;
    assign comb3 = comb2 - dly3;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            dec_cnt <= '0;
        end else if (dump) begin
            dec_cnt <= '0;
        end else if (conv.samp_en) begin
            dec_cnt <= dec_cnt + 5'h01;
        end
    end

    // RULE11 comb stages at decimated rate
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            dly1 <= '0;
            dly2 <= '0;
            dly3 <= '0;
        end else if (dump) begin
            dly1 <= integ3;
            dly2 <= comb1;
            dly3 <= comb2;
        end
    end

    // First outputs hold pipeline fill, so they are withheld
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            warm              <= '0;
            conv.result       <= '0;
            conv.result_valid <= 1'b0;
        end else begin
            conv.result_valid <= 1'b0;
            if (dump) begin
                if (warm != WARMUP) begin
                    warm <= warm + 2'h1;
                end else begin
                    conv.result_valid <= 1'b1;
                end
                // All-ones density saturates to full scale
                conv.result <= (comb3 >= CIC_FULL) ? {DATA_W{1'b1}} : comb3[DATA_W-1:0];
            end
        end
    end
endmodule // cpt_sinc3

// file: verilog/cpt_top.sv
`timescale 1ns/1ps
module cpt_top (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic        sensor_input_i,
    output logic             excitation_output_o,
    output logic [cpt_pkg::DAC_W-1:0] offset_cap_dac_o,
    output logic             prox_out_o
);
    import cpt_pkg::*;

    function automatic logic signed [DATA_W+1:0] cpt_sx(input logic [DATA_W-1:0] v);
        return signed'({2'b00, v});
    endfunction

    function automatic logic [31:0] cpt_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  strb,
                                              input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return res & mask;
    endfunction

    logic                     sens_meta;
    logic                     sens_sync;
    logic [7:0]               samp_cnt;
    logic                     samp_en;
    logic [31:0]              cfg_reg;
    logic [31:0]              sens_reg;
    logic [31:0]              fixthr_reg;
    logic [DATA_W-1:0]        data_reg;
    logic                     data_rdy;
    logic signed [ACC_W-1:0]  avg_acc;
    logic signed [ACC_W-1:0]  avg_diff;
    logic signed [ACC_W-1:0]  avg_step;
    logic                     avg_init;
    logic [DATA_W-1:0]        avg_int;
    logic [4:0]               avg_shift;
    logic signed [DATA_W+1:0] d_s;
    logic signed [DATA_W+1:0] a_s;
    logic signed [DATA_W+1:0] s_s;
    logic signed [DATA_W+1:0] t_s;
    logic signed [DATA_W+1:0] band_hi;
    logic signed [DATA_W+1:0] band_lo;
    logic                     next_prox;
    cpt_mode_t                mode;
    logic                     aw_held;
    logic [7:0]               aw_addr;
    logic                     w_held;
    logic [31:0]              w_data;
    logic [3:0]               w_strb;
    logic                     do_write;
    logic                     rd_take;
    logic                     data_read;

    cpt_conv_if conv ();

    // Pin crosses into the clock domain through two flops
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            sens_meta <= 1'b0;
            sens_sync <= 1'b0;
        end else begin
            sens_meta <= sensor_input_i;
            sens_sync <= sens_meta;
        end
    end

    // One modulator sample every SAMPLE_DIV clocks
    assign samp_en = (samp_cnt == SAMPLE_DIV - 8'h01);

    // Excitation toggles once per modulator sample
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            samp_cnt            <= '0;
            excitation_output_o <= 1'b0;
        end else if (samp_en) begin
            samp_cnt            <= '0;
            excitation_output_o <= ~excitation_output_o;
        end else begin
            samp_cnt <= samp_cnt + 8'h01;
        end
    end

    assign conv.samp_en = samp_en;
    assign conv.mod_bit = sens_sync;

    cpt_sinc3 u_filt (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .conv      (conv.filt)
    );

    // RULE9 straight binary code keeps DAC monotonic
    // RULE10 code scales the offset range ahead of the 4 pF span
    assign offset_cap_dac_o = cfg_reg[CFG_DAC_LSB +: DAC_W];
    assign mode             = cpt_mode_t'(cfg_reg[CFG_MODE_LSB +: 2]);

    // RULE12 each result lands in the readable data word
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            data_reg <= '0;
        end else if (conv.result_valid) begin
            data_reg <= conv.result;
        end
    end

    // Set wins over the clear by a data read
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            data_rdy <= 1'b0;
        end else if (conv.result_valid) begin
            data_rdy <= 1'b1;
        end else if (data_read) begin
            data_rdy <= 1'b0;
        end
    end

    // RULE8 time constant 2^(sel+1): 2 up to 65536
    assign avg_shift = {1'b0, cfg_reg[CFG_SEL_LSB +: SEL_W]} + 5'h01;
    assign avg_diff  = signed'({2'b00, conv.result, {FRAC_W{1'b0}}}) - avg_acc;
    assign avg_step  = avg_diff >>> avg_shift;
    // Truncating shift: slow settings stop a fraction short of the data
    assign avg_int   = avg_acc[FRAC_W +: DATA_W];

    // RULE7 first-order exponential settling per conversion
    // RULE15 average moves only on a completed result
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            avg_acc  <= '0;
            avg_init <= 1'b0;
        end else if (conv.result_valid) begin
            avg_init <= 1'b1;
            if (!avg_init) begin
                avg_acc <= signed'({2'b00, conv.result, {FRAC_W{1'b0}}});
            end else begin
                avg_acc <= avg_acc + avg_step;
            end
        end
    end

    // Average before this result, so a step is seen at full size
    assign d_s = cpt_sx(conv.result);
    assign a_s = avg_init ? cpt_sx(avg_int) : cpt_sx(conv.result);
    // RULE13 sensitivity is an 8-bit LSB distance
    assign s_s = cpt_sx({4'h0, sens_reg[SENS_W-1:0]});
    assign t_s = cpt_sx(fixthr_reg[DATA_W-1:0]);

    // Signed edges: a band below zero must not wrap
    assign band_hi = a_s + s_s;
    assign band_lo = a_s - s_s;

    // RULE2 fixed or adaptive threshold select
    always_comb begin
        next_prox = 1'b0;
        if (cfg_reg[CFG_FIXED_BIT]) begin
            // RULE4 constant threshold crossing
            // RULE5 polarity in fixed mode; window codes fall back to it
            next_prox = mode[0] ? (d_s > t_s) : (d_s < t_s);
        end else begin
            // RULE3 adaptive band tracks slow drift
            // RULE14 band edges one sensitivity from average
            unique case (mode)
                // RULE5 polarity in adaptive mode
                MODE_POS:     next_prox = d_s > band_hi;
                MODE_NEG:     next_prox = d_s < band_lo;
                // RULE6 window comparisons
                MODE_IN_WIN:  next_prox = (d_s >= band_lo) && (d_s <= band_hi);
                MODE_OUT_WIN: next_prox = (d_s < band_lo) || (d_s > band_hi);
            endcase
        end
    end

    // RULE1 active-high proximity pin
    // RULE15 pin changes only at conversion points
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            prox_out_o <= 1'b0;
        end else if (conv.result_valid) begin
            prox_out_o <= next_prox;
        end
    end

    // Write path: address and data accepted in either order
    // Readies stay low while a response waits: one write at a time
    assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
    assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
    assign do_write        = aw_held && w_held && !s_axi_bvalid_o;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_i;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_i;
            w_strb <= s_axi_wstrb_i;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cfg_reg    <= CFG_RST;
            sens_reg   <= SENS_RST;
            fixthr_reg <= FIXTHR_RST;
        end else if (do_write) begin
            if (aw_addr == ADDR_CFG) begin
                cfg_reg <= cpt_merge(cfg_reg, w_data, w_strb, CFG_MASK);
            end
            if (aw_addr == ADDR_SENS) begin
                sens_reg <= cpt_merge(sens_reg, w_data, w_strb, SENS_MASK);
            end
            if (aw_addr == ADDR_FIXTHR) begin
                fixthr_reg <= cpt_merge(fixthr_reg, w_data, w_strb, FIXTHR_MASK);
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= (aw_addr == ADDR_CFG || aw_addr == ADDR_SENS ||
                               aw_addr == ADDR_FIXTHR) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // Read path: one outstanding read, answered the next cycle
    assign s_axi_arready_o = !s_axi_rvalid_o;
    assign rd_take         = s_axi_arvalid_i && s_axi_arready_o;
    // A DATA read clears the ready flag
    assign data_read       = rd_take && (s_axi_araddr_i == ADDR_DATA);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= '0;
            s_axi_rresp_o  <= RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o  <= RESP_OKAY;
            s_axi_rdata_o  <= '0;
            unique case (s_axi_araddr_i)
                ADDR_STATUS: begin
                    s_axi_rdata_o[ST_OUT_BIT] <= prox_out_o;
                    s_axi_rdata_o[ST_RDY_BIT] <= data_rdy;
                    s_axi_rdata_o[ST_AVG_BIT] <= avg_init;
                end
                ADDR_DATA:   s_axi_rdata_o[DATA_W-1:0] <= data_reg;
                ADDR_AVG:    s_axi_rdata_o[DATA_W-1:0] <= avg_int;
                ADDR_CFG:    s_axi_rdata_o <= cfg_reg;
                ADDR_SENS:   s_axi_rdata_o <= sens_reg;
                ADDR_FIXTHR: s_axi_rdata_o <= fixthr_reg;
                default:     s_axi_rresp_o <= RESP_SLVERR;
            endcase
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end
endmodule // cpt_top

// file: tb/cpt_top_sva.sv
`timescale 1ns/1ps
module cpt_top_sva
    import cpt_pkg::*;
(
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    input wire logic [7:0]  s_axi_awaddr_i,
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0]  s_axi_wstrb_i,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic [7:0]  s_axi_araddr_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0]  s_axi_rresp_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic        excitation_output_o,
    input wire logic [cpt_pkg::DAC_W-1:0] offset_cap_dac_o,
    input wire logic        prox_out_o
);
    logic [6:0] gap;
    logic [5:0] cfg_dac;
    wire        aw_hs = s_axi_awvalid_i && s_axi_awready_o;
    wire        w_hs  = s_axi_wvalid_i && s_axi_wready_o;
    wire        ar_hs = s_axi_arvalid_i && s_axi_arready_o;

    default clocking dcb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    // Cycles since the flag last moved
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || $changed(prox_out_o)) begin
            gap <= 7'h00;
        end else if (gap != 7'h7F) begin
            gap <= gap + 7'h01;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (aw_hs && s_axi_awaddr_i == ADDR_CFG) begin
            cfg_dac <= s_axi_wdata_i[13:8];
        end
    end

    a_prox_spacing: assert property ($changed(prox_out_o) |-> gap >= 7'h3C)
        else $error("flag moved between results");
    a_exc_period: assert property ($changed(excitation_output_o) |=>
        $stable(excitation_output_o) [*3] ##1 $changed(excitation_output_o))
        else $error("excitation period wrong");
    a_dac_follows: assert property (aw_hs && w_hs && s_axi_awaddr_i == ADDR_CFG &&
        s_axi_wstrb_i == 4'hF |=> ##[0:2] offset_cap_dac_o == cfg_dac)
        else $error("offset code not applied");
    a_wr_answer: assert property (aw_hs && w_hs |-> ##2 s_axi_bvalid_o)
        else $error("write response late");
    a_b_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
        s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped");
    a_ro_refuse: assert property (aw_hs && w_hs && s_axi_awaddr_i < ADDR_CFG |->
        ##2 s_axi_bresp_o == RESP_SLVERR)
        else $error("read-only write accepted");
    a_rd_answer: assert property (ar_hs |=> s_axi_rvalid_o && !s_axi_arready_o)
        else $error("read response late");
    a_r_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
        s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped");
    a_bad_rd: assert property (ar_hs && s_axi_araddr_i > ADDR_FIXTHR |=>
        s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0)
        else $error("unmapped read not refused");
    a_ready_block: assert property (s_axi_bvalid_o |->
        !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken while response pending");
endmodule // cpt_top_sva

// file: tb/cpt_sensor_model.sv
`timescale 1ns/1ps
module cpt_sensor_model (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        excitation_i,
    input  wire logic [12:0] level_i,
    output logic             bit_o
);
    logic        exc_q;
    logic [11:0] acc;
    logic [12:0] sum;
    // Level 13'h1000 gives a solid ones stream
    assign sum = {1'b0, acc} + level_i;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            exc_q <= 1'b0;
            acc   <= 12'h000;
            bit_o <= 1'b0;
        end else begin
            exc_q <= excitation_i;
            // one charge decision per excitation edge
            if (exc_q != excitation_i) begin
                acc   <= sum[11:0];
                bit_o <= sum[12];
            end
        end
    end
endmodule // cpt_sensor_model

// file: tb/cpt_top_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end
module cpt_top_tb;
    import cpt_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, excitation_output, prox, sens_bit;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic [5:0]  dac;
    logic [12:0] level = 13'h0000;
    logic [31:0] modes [5] = '{32'h2AF0, 32'h2AF2, 32'h2AF3, 32'h2AF5, 32'h2AF4};
    logic        hits [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    int          num_errors = 0;
    int          samples_checked = 0;

    always #5 clk = ~clk;

    cpt_top i_cpt_top (
        .sys_clk_i(clk), .rst_n_i(rst_n),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .sensor_input_i(sens_bit),
        .excitation_output_o(excitation_output), .offset_cap_dac_o(dac), .prox_out_o(prox));

    cpt_sensor_model i_cpt_sensor_model (
        .sys_clk_i(clk), .rst_n_i(rst_n), .excitation_i(excitation_output), .level_i(level),
        .bit_o(sens_bit));

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r);
        logic ta;
        logic tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge clk);
            ta = ta || awready;
            tw = tw || wready;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        // Ready rises on the same edge as the response, so it never waits
        @(posedge clk);
        bready <= 1'b1;
        do @(negedge clk); while (!bvalid);
        resp = bresp;
        @(posedge clk);
        bready <= 1'b0;
        `CHK(resp, r)
    endtask

    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(negedge clk); while (!arready);
        @(posedge clk);
        arvalid <= 1'b0;
        @(posedge clk);
        rready <= 1'b1;
        do @(negedge clk); while (!rvalid);
        rd   = rdata;
        resp = rresp;
        @(posedge clk);
        rready <= 1'b0;
        @(negedge clk);
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        rd_reg(a);
        `CHK(rd, e)
        `CHK(resp, r)
    endtask

    task automatic cfg(input logic [31:0] d);
        wr(ADDR_CFG, d, 4'hF, RESP_OKAY);
        @(negedge clk);
        `CHK(dac, d[13:8])
    endtask

    // Results come every 64 clocks; end between edges
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        chk_rd(ADDR_CFG, CFG_RST, RESP_OKAY);
        chk_rd(ADDR_SENS, SENS_RST, RESP_OKAY);
        chk_rd(ADDR_FIXTHR, FIXTHR_RST, RESP_OKAY);
        chk_rd(8'h18, 32'h0, RESP_SLVERR);
        wr(ADDR_DATA, 32'h123, 4'hF, RESP_SLVERR);
        wr(ADDR_SENS, 32'h1FF, 4'hF, RESP_OKAY);
        chk_rd(ADDR_SENS, 32'hFF, RESP_OKAY);
        wr(ADDR_SENS, 32'h55, 4'h0, RESP_OKAY);
        chk_rd(ADDR_SENS, 32'hFF, RESP_OKAY);
        wr(ADDR_SENS, SENS_RST, 4'hF, RESP_OKAY);
        cfg(32'h3FF1);
        chk_rd(ADDR_CFG, 32'h3FF1, RESP_OKAY);
        settle(600);
        chk_rd(ADDR_DATA, 32'h0, RESP_OKAY);
        `CHK(prox, 1'b0)
        // Fast step against the slowest average
        level <= 13'h1000;
        settle(512);
        chk_rd(ADDR_DATA, 32'hFFF, RESP_OKAY);
        chk_rd(ADDR_AVG, 32'h0, RESP_OKAY);
        `CHK(prox, 1'b1)
        rd_reg(ADDR_STATUS);
        `CHK(rd[0], 1'b1)
        foreach (modes[i]) begin
            cfg(modes[i]);
            settle(130);
            `CHK(prox, hits[i])
        end
        // Equal to the threshold is not a crossing
        wr(ADDR_FIXTHR, 32'hFFF, 4'hF, RESP_OKAY);
        cfg(32'h2AF5);
        settle(130);
        `CHK(prox, 1'b0)
        wr(ADDR_FIXTHR, 32'h800, 4'hF, RESP_OKAY);
        cfg(32'h2AF4);
        level <= 13'h0000;
        settle(512);
        `CHK(prox, 1'b1)
        // Fastest average absorbs the step
        cfg(32'h0001);
        settle(256);
        level <= 13'h1000;
        settle(1024);
        rd_reg(ADDR_AVG);
        `CHK(rd >= 32'hFFE, 1'b1)
        `CHK(prox, 1'b0)
        // In-window holds once the average has caught up
        cfg(32'h0002);
        settle(130);
        `CHK(prox, 1'b1)
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
endmodule // cpt_top_tb

bind cpt_top cpt_top_sva i_cpt_top_sva (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wdata_i(s_axi_wdata_i), .s_axi_wstrb_i(s_axi_wstrb_i),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
    .excitation_output_o(excitation_output_o), .offset_cap_dac_o(offset_cap_dac_o),
    .prox_out_o(prox_out_o));
